// ===== rtl/rjd_params.svh
/*
  Constants for the relative jump decoder: opcodes, flag positions,
  bus addresses and cycle counts. Assumes an 8-bit condition code
  register laid out S X H I N Z V C from bit 7 down to bit 0.
*/
`ifndef RJD_PARAMS_SVH
`define RJD_PARAMS_SVH

// ============================================================
// opcodes
`define RJD_OP_ALWAYS      8'h20
`define RJD_OP_NEVER       8'h21
`define RJD_OP_UHIGHER     8'h22
`define RJD_OP_ULOWSAME    8'h23
`define RJD_OP_CARRY_CLR   8'h24
`define RJD_OP_CARRY_SET   8'h25
`define RJD_OP_NONZERO     8'h26
`define RJD_OP_EQUAL       8'h27
`define RJD_OP_OVF_CLR     8'h28
`define RJD_OP_OVF_SET     8'h29
`define RJD_OP_POSITIVE    8'h2A
`define RJD_OP_NEGATIVE    8'h2B
`define RJD_OP_SGE         8'h2C
`define RJD_OP_SLT         8'h2D
`define RJD_OP_SGT         8'h2E
`define RJD_OP_SLE         8'h2F
`define RJD_OP_GROUP       4'h2

// ============================================================
// condition code bit positions
`define RJD_CCR_C          0
`define RJD_CCR_V          1
`define RJD_CCR_Z          2
`define RJD_CCR_N          3

// ============================================================
// bus and timing
`define RJD_IDLE_ADDR      16'hFFFF
`define RJD_PC_STEP        16'h0002
`define RJD_NEXT_BYTE      16'h0001
`define RJD_BUS_CYCLES     3
`define RJD_RESET_PC       16'h0000
`define RJD_RESET_CCR      8'h00

`endif

// ===== rtl/rjd_pkg.sv
/*
  Types shared by the relative jump decoder files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rjd_pkg;

  // ============================================================
  // sequencer states, gray coded along the fetch path
  typedef enum logic [1:0] {
    RJD_IDLE     = 2'b00,
    RJD_FETCH_OP = 2'b01,
    RJD_FETCH_RL = 2'b11,
    RJD_DEAD     = 2'b10
  } rjd_state_e;

  // ============================================================
  // memory bus request
  typedef struct packed {
    logic        valid;
    logic        rw;
    logic [15:0] addr;
  } rjd_bus_s;

endpackage : rjd_pkg

// ===== rtl/rjd_cond_eval.sv
/*
  Jump condition evaluator: registers whether the held opcode takes
  its jump given the condition codes. Assumes opcode and flags are
  stable for the cycle in which the result is wanted.
*/
`timescale 1ns/1ps
`include "rjd_params.svh"

module rjd_cond_eval (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] condition_code_register,
  output logic            taken,
  output logic            is_branch
);
  import rjd_pkg::*;

  function automatic logic cond_hit(input logic [7:0] op,
                                    input logic [7:0] f);
    logic c;
    logic v;
    logic z;
    logic n;
    c = f[`RJD_CCR_C];
    v = f[`RJD_CCR_V];
    z = f[`RJD_CCR_Z];
    n = f[`RJD_CCR_N];
    case (op)
      `RJD_OP_ALWAYS:    cond_hit = 1'b1;               // see (RL3)
      `RJD_OP_NEVER:     cond_hit = 1'b0;               // see (RL9)
      `RJD_OP_UHIGHER:   cond_hit = ~(c | z);           // see (RL9)
      `RJD_OP_ULOWSAME:  cond_hit = c | z;              // see (RL9)
      `RJD_OP_CARRY_CLR: cond_hit = ~c;                 // see (RL9)
      `RJD_OP_CARRY_SET: cond_hit = c;                  // see (RL9)
      `RJD_OP_NONZERO:   cond_hit = ~z;                 // see (RL1)
      `RJD_OP_EQUAL:     cond_hit = z;                  // see (RL9)
      `RJD_OP_OVF_CLR:   cond_hit = ~v;                 // see (RL9)
      `RJD_OP_OVF_SET:   cond_hit = v;                  // see (RL9)
      `RJD_OP_POSITIVE:  cond_hit = ~n;                 // see (RL2)
      `RJD_OP_NEGATIVE:  cond_hit = n;                  // see (RL9)
      `RJD_OP_SGE:       cond_hit = ~(n ^ v);           // see (RL8)
      `RJD_OP_SLT:       cond_hit = n ^ v;              // see (RL8)
      `RJD_OP_SGT:       cond_hit = ~(z | (n ^ v));     // see (RL8)
      `RJD_OP_SLE:       cond_hit = z | (n ^ v);        // see (RL8)
      default:           cond_hit = 1'b0;
    endcase
  endfunction : cond_hit

  // ============================================================
  // registered result
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      taken <= 1'b0;
    end else begin
      taken <= cond_hit(opcode, condition_code_register);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      is_branch <= 1'b0;
    end else begin
      is_branch <= (opcode[7:4] == `RJD_OP_GROUP);
    end
  end

  // ============================================================
  // checks
  a_nonzero_flag: assert property ( // see (RL1)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h26) |=> (taken == !$past(condition_code_register[2])))
    else $error("nonzero jump ignores zero flag");

  a_positive_flag: assert property ( // see (RL2)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h2A) |=> (taken == !$past(condition_code_register[3])))
    else $error("positive jump ignores negative flag");

  a_signed_greater: assert property ( // see (RL8)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h2E) |=>
      (taken == !($past(condition_code_register[2]) | ($past(condition_code_register[3]) ^ $past(condition_code_register[1])))))
    else $error("signed greater condition wrong");

  a_signed_less: assert property ( // see (RL8)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h2D) |=> (taken == ($past(condition_code_register[3]) ^ $past(condition_code_register[1]))))
    else $error("signed less condition wrong");

  a_unsigned_higher: assert property ( // see (RL9)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h22) |=> (taken == !($past(condition_code_register[0]) | $past(condition_code_register[2]))))
    else $error("unsigned higher condition wrong");

  a_never_jumps: assert property ( // see (RL9)
    @(posedge clock) disable iff (sys_rst)
    (opcode == 8'h21) |=> !taken)
    else $error("never jump was taken");

endmodule : rjd_cond_eval

// ===== rtl/rjd_top.sv
/*
  Relative jump decode and execute sequencer: fetches opcode and
  displacement, runs the idle cycle, then posts the new program
  counter. Assumes the core holds the condition codes steady during
  the sequence and memory returns read data within each bus
  request cycle.
*/
// Behaviour
// (RL1) opcode 26 jumps only when the zero flag is clear.
// (RL2) opcode 2A jumps only when the negative flag is clear.
// (RL3) opcode 20 always loads the computed target.
// (RL4) second byte is a signed 8-bit offset, sign-extended before adding.
// (RL5) taken jump loads opcode address plus 2 plus displacement.
// (RL6) three reads: opcode address, next address, then idle address FFFF.
// (RL7) all eight condition code bits stay unchanged.
// (RL8) signed jumps 2C 2D 2E 2F test zero, negative and overflow.
// (RL9) unsigned, carry, equal, negative, overflow and never jumps test flags.
// (RL10) a false condition gives opcode address plus 2, still three cycles.
`timescale 1ns/1ps
`include "rjd_params.svh"

module rjd_top (
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic            start,
  input  wire logic [15:0]     start_pc,
  input  wire logic [7:0]      ccr_in,
  input  wire logic [7:0]      mem_rdata,
  output rjd_pkg::rjd_bus_s    bus,
  output logic      [15:0]     pc_out,
  output logic      [7:0]      ccr_out,
  output logic                 busy,
  output logic                 done,
  output logic                 taken,
  output logic                 bad_opcode
);
  import rjd_pkg::*;

  // ============================================================
  // state
  rjd_state_e  state;
  rjd_state_e  next_state;
  logic [15:0] pc_op;
  logic [7:0]  opcode;
  logic [7:0]  rel;
  logic        cond_taken;
  logic        cond_branch;
  logic [15:0] next_target;
  logic [15:0] next_fall;

  assign next_fall   = pc_op + `RJD_PC_STEP;                 // see (RL10)
  assign next_target = next_fall + {{8{rel[7]}}, rel};       // see (RL4) (RL5)

  always_comb begin
    next_state = state;
    case (state)
      RJD_IDLE:     if (start) next_state = RJD_FETCH_OP;
      RJD_FETCH_OP: next_state = RJD_FETCH_RL;
      RJD_FETCH_RL: next_state = RJD_DEAD;
      RJD_DEAD:     next_state = RJD_IDLE;
      default:      next_state = RJD_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RJD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != RJD_IDLE);
    end
  end

  // ============================================================
  // capture of address and instruction bytes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_op <= `RJD_RESET_PC;
    end else if (state == RJD_IDLE && start) begin
      pc_op <= start_pc;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      opcode <= 8'h00;
    end else if (state == RJD_FETCH_OP) begin
      opcode <= mem_rdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rel <= 8'h00;
    end else if (state == RJD_FETCH_RL) begin
      rel <= mem_rdata;                                      // see (RL4)
    end
  end

  // ============================================================
  // condition evaluation, result ready in the idle cycle
  rjd_cond_eval u_cond (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .opcode    (opcode),
    .condition_code_register       (ccr_in),
    .taken     (cond_taken),
    .is_branch (cond_branch)
  );

  // ============================================================
  // memory bus: opcode, displacement, then idle address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus.valid <= 1'b0;
      bus.rw    <= 1'b1;
      bus.addr  <= `RJD_IDLE_ADDR;
    end else begin
      bus.rw <= 1'b1;                                        // see (RL6)
      case (next_state)
        RJD_FETCH_OP: begin
          bus.valid <= 1'b1;
          bus.addr  <= start_pc;                             // see (RL6)
        end
        RJD_FETCH_RL: begin
          bus.valid <= 1'b1;
          bus.addr  <= pc_op + `RJD_NEXT_BYTE;               // see (RL6)
        end
        RJD_DEAD: begin
          bus.valid <= 1'b1;
          bus.addr  <= `RJD_IDLE_ADDR;                       // see (RL6)
        end
        default: begin
          bus.valid <= 1'b0;
          bus.addr  <= `RJD_IDLE_ADDR;
        end
      endcase
    end
  end

  // ============================================================
  // result to the core
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_out     <= `RJD_RESET_PC;
      taken      <= 1'b0;
      bad_opcode <= 1'b0;
    end else if (state == RJD_DEAD) begin
      pc_out     <= cond_taken ? next_target : next_fall;    // see (RL5) (RL10)
      taken      <= cond_taken;
      bad_opcode <= !cond_branch;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= (state == RJD_DEAD);
    end
  end

  // flags pass through untouched
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_out <= `RJD_RESET_CCR;
    end else begin
      ccr_out <= ccr_in;                                     // see (RL7)
    end
  end

  // ============================================================
  // checks
  a_bus_three_cycles: assert property ( // see (RL6)
    @(posedge clock) disable iff (sys_rst)
    (state == RJD_IDLE && start) |=>
      (bus.valid && bus.addr == pc_op)
      ##1 (bus.valid && bus.addr == 16'(pc_op + 16'h0001))
      ##1 (bus.valid && bus.addr == 16'hFFFF)
      ##1 (done && !bus.valid))
    else $error("jump bus sequence wrong");

  a_bus_reads_only: assert property ( // see (RL6)
    @(posedge clock) disable iff (sys_rst)
    bus.valid |-> bus.rw)
    else $error("jump bus cycle is not a read");

  a_taken_target: assert property ( // see (RL5)
    @(posedge clock) disable iff (sys_rst)
    (done && taken) |->
      (pc_out == 16'(pc_op + 16'h0002 + {{8{rel[7]}}, rel})))
    else $error("taken jump target wrong");

  a_fall_through: assert property ( // see (RL10)
    @(posedge clock) disable iff (sys_rst)
    (done && !taken) |-> (pc_out == 16'(pc_op + 16'h0002)))
    else $error("untaken jump address wrong");

  a_always_taken: assert property ( // see (RL3)
    @(posedge clock) disable iff (sys_rst)
    (done && opcode == 8'h20) |-> taken)
    else $error("unconditional jump not taken");

  a_ccr_unchanged: assert property ( // see (RL7)
    @(posedge clock) disable iff (sys_rst)
    (done && $stable(ccr_in)) |-> (ccr_out == ccr_in))
    else $error("condition codes altered");

  a_busy_span: assert property ( // see (RL6)
    @(posedge clock) disable iff (sys_rst)
    $rose(busy) |-> busy [*3] ##1 !busy)
    else $error("busy span not three cycles");

endmodule : rjd_top

// ===== tb/rjd_mem_model.sv
/*
  Program memory partner for the relative jump decoder bench.
  Assumes the bench places the opcode byte at prog_addr and the
  displacement byte right after it; reads answer within the cycle.
*/
`timescale 1ns/1ps

module rjd_mem_model (
  input  wire logic              clock,
  input  wire rjd_pkg::rjd_bus_s bus,
  input  wire logic [15:0]       prog_addr,
  input  wire logic [7:0]        op_byte,
  input  wire logic [7:0]        disp_byte,
  output logic      [7:0]        mem_rdata
);
  import rjd_pkg::*;
  logic [7:0] last_data = 8'hA5;

  // ============================================================
  // combinational read in the same cycle as the address
  always_comb begin
    if (bus.valid && bus.addr == prog_addr) begin
      mem_rdata = op_byte;
    end else if (bus.valid && bus.addr == prog_addr + 16'h0001) begin
      mem_rdata = disp_byte;
    end else begin
      mem_rdata = ~last_data;
    end
  end

  // ============================================================
  // unselected cycles show a value that flips every cycle
  always_ff @(posedge clock) begin
    last_data <= mem_rdata;
  end
endmodule : rjd_mem_model

// ===== tb/relative_jump_decode_bench.sv
/*
  Self-checking bench for the relative jump decoder.
  Assumes rjd_top and the rjd_mem_model program memory partner.
*/
`timescale 1ns/1ps

module relative_jump_decode_bench;
  import rjd_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  condition_code_register;
    logic [7:0]  disp;
    logic [15:0] pc;
    logic        tk;
  } rjd_row_s;
  logic        clock;
  logic        sys_rst;
  logic        start;
  logic [15:0] start_pc;
  logic [15:0] prog_addr;
  logic [15:0] pc_out;
  logic [7:0]  ccr_in;
  logic [7:0]  ccr_out;
  logic [7:0]  mem_rdata;
  logic [7:0]  op_byte;
  logic [7:0]  disp_byte;
  logic        busy;
  logic        done;
  logic        taken;
  logic        bad_opcode;
  rjd_bus_s    bus;
  int          err_count;
  int          checks_done;
  rjd_row_s    rows [0:32] = '{
    '{8'h26,8'h00,8'h05,16'h1000,1'h1}, '{8'h26,8'h04,8'h05,16'h1000,1'h0},
    '{8'h26,8'h00,8'h05,16'hFFFE,1'h1}, '{8'h2A,8'h00,8'h80,16'h0000,1'h1},
    '{8'h2A,8'h08,8'h7F,16'h1020,1'h0}, '{8'h20,8'hFF,8'h7F,16'hFFF0,1'h1},
    '{8'h20,8'h00,8'h80,16'h0010,1'h1}, '{8'h21,8'h00,8'h10,16'h1030,1'h0},
    '{8'h22,8'h00,8'h10,16'h2000,1'h1}, '{8'h22,8'h04,8'h10,16'h2000,1'h0},
    '{8'h23,8'h01,8'hF0,16'h2010,1'h1}, '{8'h23,8'h00,8'hF0,16'h2010,1'h0},
    '{8'h24,8'h00,8'h20,16'h2020,1'h1}, '{8'h24,8'h01,8'h20,16'h2020,1'h0},
    '{8'h25,8'h01,8'h20,16'h2030,1'h1}, '{8'h25,8'h00,8'h20,16'h2030,1'h0},
    '{8'h27,8'h04,8'h30,16'h3000,1'h1}, '{8'h27,8'h00,8'h30,16'h3000,1'h0},
    '{8'h28,8'h00,8'h30,16'h3010,1'h1}, '{8'h28,8'h02,8'h30,16'h3010,1'h0},
    '{8'h29,8'h02,8'h30,16'h3020,1'h1}, '{8'h2B,8'h08,8'h30,16'h3030,1'h1},
    '{8'h2C,8'h0A,8'h40,16'h4000,1'h1}, '{8'h2C,8'h08,8'h40,16'h4000,1'h0},
    '{8'h2D,8'h02,8'h40,16'h4010,1'h1}, '{8'h2D,8'h0A,8'h40,16'h4010,1'h0},
    '{8'h2E,8'h00,8'h40,16'h4020,1'h1}, '{8'h2E,8'h0A,8'h40,16'h4020,1'h1},
    '{8'h2E,8'h04,8'h40,16'h4020,1'h0}, '{8'h2E,8'h08,8'h40,16'h4020,1'h0},
    '{8'h2F,8'h04,8'h40,16'h4030,1'h1}, '{8'h2F,8'h00,8'h40,16'h4030,1'h0},
    '{8'h12,8'h00,8'h40,16'hFFFE,1'h0}};

  rjd_top rjd_top_inst (.clock(clock), .sys_rst(sys_rst), .start(start),
    .start_pc(start_pc), .ccr_in(ccr_in), .mem_rdata(mem_rdata),
    .bus(bus), .pc_out(pc_out), .ccr_out(ccr_out), .busy(busy),
    .done(done), .taken(taken), .bad_opcode(bad_opcode));
  rjd_mem_model rjd_mem_model_inst (.clock(clock), .bus(bus),
    .prog_addr(prog_addr), .op_byte(op_byte), .disp_byte(disp_byte),
    .mem_rdata(mem_rdata));

  always #20 clock = ~clock;

  // ============================================================
  // compare and report
  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ============================================================
  // one jump, entered at a falling edge; hold keeps start up for the first two busy cycles
  task automatic run(input rjd_row_s r, input logic hold);
    logic [15:0] exp_pc;
    logic [15:0] exp_addr;
    exp_pc = r.pc + 16'h0002 + (r.tk ? {{8{r.disp[7]}}, r.disp} : 16'h0000);
    start = 1'h1;
    start_pc = r.pc;
    prog_addr = r.pc;
    ccr_in = r.condition_code_register;
    op_byte = r.op;
    disp_byte = r.disp;
    for (int c = 1; c <= 3; c++) begin
      @(negedge clock);
      start = hold && c < 3;
      start_pc = ~r.pc;
      chk("bus_flags", 16'h0007,
          {13'h0000, busy, bus.valid, bus.rw});
      exp_addr = (c == 1) ? r.pc : (c == 2) ? r.pc + 16'h0001 : 16'hFFFF;
      chk("addr", exp_addr, bus.addr);
      chk("ccr_out", {8'h00, r.condition_code_register}, {8'h00, ccr_out});
    end
    @(negedge clock);
    chk("done_flags", 16'h0004,
        {13'h0000, done, busy, bus.valid});
    chk("idle_addr", 16'hFFFF, bus.addr);
    chk("pc_out", exp_pc, pc_out);
    chk("taken", {15'h0000, r.tk},
        {15'h0000, taken});
    chk("bad_opcode", {15'h0000, r.op[7:4] != 4'h2},
        {15'h0000, bad_opcode});
    chk("ccr_kept", {8'h00, r.condition_code_register}, {8'h00, ccr_out});
    $display("test op %h ccr %h pc %h done", r.op, r.condition_code_register, r.pc);
  endtask : run

  // ============================================================
  // main sequence
  initial begin
    clock = 1'h0;
    sys_rst = 1'h1;
    start = 1'h0;
    start_pc = 16'h0000;
    prog_addr = 16'h0000;
    ccr_in = 8'h00;
    op_byte = 8'h00;
    disp_byte = 8'h00;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(negedge clock);
    sys_rst = 1'h0;
    @(negedge clock);
    chk("reset_flags", 16'h0001, {10'h000, busy, done, taken, bad_opcode,
        bus.valid, bus.rw});
    chk("reset_addr", 16'hFFFF, bus.addr);
    chk("reset_pc", 16'h0000, pc_out);
    $display("test reset done");
    foreach (rows[i]) run(rows[i], 1'h0);
    // start held while busy is ignored
    run('{8'h20, 8'h00, 8'h10, 16'h2000, 1'h1}, 1'h1);
    // reset in the middle of a jump
    start = 1'h1;
    start_pc = 16'h3000;
    prog_addr = 16'h3000;
    @(negedge clock);
    start = 1'h0;
    @(negedge clock);
    sys_rst = 1'h1;
    #1;
    chk("abort_flags", 16'h0000, {13'h0000, busy, done, bus.valid});
    chk("abort_pc", 16'h0000, pc_out);
    @(negedge clock);
    sys_rst = 1'h0;
    $display("test abort done");
    run(rows[0], 1'h0);
    results;
  end

  // ============================================================
  // watchdog
  initial begin
    #(40 * 1000);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    results;
  end
endmodule : relative_jump_decode_bench
